//--- design/trigger_line_assignment_consts.svh
`ifndef TRIGGER_LINE_ASSIGNMENT_CONSTS_SVH
`define TRIGGER_LINE_ASSIGNMENT_CONSTS_SVH
// lowest and highest legal bus line number
`define TLA_LINE_MIN 3'h1
`define TLA_LINE_MAX 3'h6
// defaults after reset command or preset
`define TLA_IN_RESET 3'h1
`define TLA_OUT_RESET 3'h2
`define TLA_SHARED_RESET 3'h1
// number of sequencing layers
`define TLA_NUM_LAYERS 3
`endif

//--- design/trigger_line_assignment_pkg.sv
`default_nettype none
package trigger_line_assignment_pkg;
  // which selection a write command targets
  typedef enum logic [1:0] {
    sel_input,
    sel_output,
    sel_shared,
    sel_protocol
  } sel_kind_t;
  // one configuration command from the interpreter
  typedef struct packed {
    logic valid;
    logic [1:0] layer;
    sel_kind_t kind;
    logic [2:0] line;
  } cfg_cmd_t;
endpackage : trigger_line_assignment_pkg
`default_nettype wire

//--- design/trigger_line_assignment.sv
// Overview of operation
// - each layer holds input line 1..6
// - reset or preset sets inputs to 1
// - each layer holds output line 1..6
// - reset or preset sets outputs to 2
// - input equal to output: error, keep
// - output equal to input: error, keep
// - trigger layer holds shared line selection
// - reset or preset sets shared line 1
// - query returns programmed input line
// - trigger layer: separate or shared protocol
// - reset selects separate; arm layers separate
`timescale 1ns/100ps
`default_nettype none
`include "trigger_line_assignment_consts.svh"
module trigger_line_assignment
  import trigger_line_assignment_pkg::*;
#(
  parameter int NUM_LAYERS = `TLA_NUM_LAYERS
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic rst, // synchronous reset, high
  input wire logic preset, // system preset pulse
  input wire cfg_cmd_t cmd, // write command
  input wire logic [1:0] query_layer, // layer to report
  output logic [2:0] query_in_line, // input line of queried layer
  output logic [2:0] query_out_line, // output line of queried layer
  output logic [2:0] shared_mode_line, // trigger layer shared line
  output logic shared_line_protocol, // 1 = shared-line mode
  output logic [3*NUM_LAYERS-1:0] sep_mode_input_line, // packed input lines
  output logic [3*NUM_LAYERS-1:0] sep_mode_output_line, // packed output lines
  output logic cmd_error // one-cycle error pulse
);
  localparam logic [1:0] TRIG_LAYER = 2'h2; // index of trigger layer

  logic [2:0] in_ff [NUM_LAYERS]; // input selections
  logic [2:0] out_ff [NUM_LAYERS]; // output selections
  logic [2:0] shared_ff; // shared line
  logic proto_ff; // protocol selection
  logic err_ff; // error pulse
  logic [2:0] qin_ff; // query result
  logic [2:0] qout_ff; // query result
  logic init; // reset or preset
  logic in_range; // line number legal
  logic lay_ok; // layer index legal

  assign init = rst | preset;
  assign in_range = (cmd.line >= `TLA_LINE_MIN) && (cmd.line <= `TLA_LINE_MAX);
  // compared as int so no bits of the parameter are cut
  assign lay_ok = int'(cmd.layer) < NUM_LAYERS;

  // per-layer separate-line selections
  genvar g;
  generate
    for (g = 0; g < NUM_LAYERS; g++) begin : g_layer
      logic hit; // command addresses this layer
      assign hit = cmd.valid && (int'(cmd.layer) == g) && in_range;
      always_ff @(posedge clk) begin
        if (init) begin
          in_ff[g] <= `TLA_IN_RESET;
          out_ff[g] <= `TLA_OUT_RESET;
        end else if (hit) begin
          // a clash with the opposite direction leaves the selection alone
          if (cmd.kind == sel_input && cmd.line != out_ff[g]) begin
            in_ff[g] <= cmd.line;
          end
          if (cmd.kind == sel_output && cmd.line != in_ff[g]) begin
            out_ff[g] <= cmd.line;
          end
        end
      end
    end
  endgenerate

  // pack the per-layer flops onto the output buses; pure wiring, one driver per bus
  always_comb begin
    for (int i = 0; i < NUM_LAYERS; i++) begin
      sep_mode_input_line[3*i +: 3] = in_ff[i];
      sep_mode_output_line[3*i +: 3] = out_ff[i];
    end
  end

  // trigger layer shared line and protocol; arm layers have no protocol choice
  always_ff @(posedge clk) begin
    if (init) begin
      shared_ff <= `TLA_SHARED_RESET;
      proto_ff <= 1'b0;
    end else if (cmd.valid && cmd.layer == TRIG_LAYER) begin
      if (cmd.kind == sel_shared && in_range) begin
        shared_ff <= cmd.line;
      end
      if (cmd.kind == sel_protocol) begin
        proto_ff <= cmd.line[0];
      end
    end
  end

  // error pulse for clash, out of range, or bad layer
  always_ff @(posedge clk) begin
    if (init) begin
      err_ff <= 1'b0;
    end else if (!cmd.valid) begin
      err_ff <= 1'b0;
    end else if (!lay_ok) begin
      err_ff <= 1'b1;
    end else if (cmd.kind == sel_protocol) begin
      err_ff <= (cmd.layer != TRIG_LAYER);
    end else if (cmd.kind == sel_shared) begin
      err_ff <= !in_range || (cmd.layer != TRIG_LAYER);
    end else if (!in_range) begin
      err_ff <= 1'b1;
    end else if (cmd.kind == sel_input) begin
      err_ff <= (cmd.line == out_ff[cmd.layer]);
    end else begin
      err_ff <= (cmd.line == in_ff[cmd.layer]);
    end
  end

  // registered query; unknown layer reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      qin_ff <= 3'h0;
      qout_ff <= 3'h0;
    end else if (int'(query_layer) < NUM_LAYERS) begin
      qin_ff <= in_ff[query_layer];
      qout_ff <= out_ff[query_layer];
    end else begin
      qin_ff <= 3'h0;
      qout_ff <= 3'h0;
    end
  end

  assign query_in_line = qin_ff;
  assign query_out_line = qout_ff;
  assign shared_mode_line = shared_ff;
  assign shared_line_protocol = proto_ff;
  assign cmd_error = err_ff;

  // assertions
  // defaults one edge after reset or preset; preset takes the same path as reset
  property p_in_reset;
    @(posedge clk) init |=> (in_ff[0] == `TLA_IN_RESET && in_ff[2] == `TLA_IN_RESET);
  endproperty
  a_in_reset: assert property (p_in_reset) else $error("input line not 1 after init");
  property p_out_reset;
    @(posedge clk) init |=> (out_ff[1] == `TLA_OUT_RESET && out_ff[2] == `TLA_OUT_RESET);
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("output line not 2 after init");
  property p_shared_reset;
    @(posedge clk) init |=> (shared_ff == `TLA_SHARED_RESET && !proto_ff);
  endproperty
  a_shared_reset: assert property (p_shared_reset) else $error("shared defaults wrong");

  // a refused separate-line request: error next cycle, selections untouched
  sequence s_sep_refused;
    ##1 (err_ff && $stable(sep_mode_input_line) && $stable(sep_mode_output_line));
  endsequence
  property p_clash_in;
    @(posedge clk) disable iff (init)
      (cmd.valid && cmd.kind == sel_input && lay_ok && cmd.line == out_ff[cmd.layer]) |-> s_sep_refused;
  endproperty
  a_clash_in: assert property (p_clash_in) else $error("input clash not rejected");
  property p_clash_out;
    @(posedge clk) disable iff (init)
      (cmd.valid && cmd.kind == sel_output && lay_ok && cmd.line == in_ff[cmd.layer]) |-> s_sep_refused;
  endproperty
  a_clash_out: assert property (p_clash_out) else $error("output clash not rejected");
  property p_range;
    @(posedge clk) disable iff (init)
      (cmd.valid && !in_range && cmd.kind == sel_shared) |=> (err_ff && shared_ff == $past(shared_ff));
  endproperty
  a_range: assert property (p_range) else $error("out of range line accepted");
  property p_range_sep;
    @(posedge clk) disable iff (init)
      (cmd.valid && !in_range && (cmd.kind == sel_input || cmd.kind == sel_output)) |-> s_sep_refused;
  endproperty
  a_range_sep: assert property (p_range_sep) else $error("out of range line stored");

  // stored selections never leave the legal range and never coincide
  property p_legal;
    @(posedge clk) disable iff (init)
      (in_ff[1] >= `TLA_LINE_MIN && in_ff[1] <= `TLA_LINE_MAX && in_ff[1] != out_ff[1]);
  endproperty
  a_legal: assert property (p_legal) else $error("input line illegal");
  property p_out_legal;
    @(posedge clk) disable iff (init) (out_ff[0] >= `TLA_LINE_MIN && out_ff[0] <= `TLA_LINE_MAX);
  endproperty
  a_out_legal: assert property (p_out_legal) else $error("output line illegal");

  // accepted requests land one edge later with no error
  property p_in_take;
    @(posedge clk) disable iff (init)
      (cmd.valid && cmd.kind == sel_input && cmd.layer == 2'h0 && in_range && cmd.line != out_ff[0])
      |=> (!err_ff && in_ff[0] == $past(cmd.line));
  endproperty
  a_in_take: assert property (p_in_take) else $error("legal input line not taken");
  property p_out_take;
    @(posedge clk) disable iff (init)
      (cmd.valid && cmd.kind == sel_output && cmd.layer == 2'h1 && in_range && cmd.line != in_ff[1])
      |=> (!err_ff && out_ff[1] == $past(cmd.line));
  endproperty
  a_out_take: assert property (p_out_take) else $error("legal output line not taken");
  property p_shared_set;
    @(posedge clk) disable iff (init)
      (cmd.valid && cmd.kind == sel_shared && cmd.layer == TRIG_LAYER && in_range)
      |=> (shared_ff == $past(cmd.line));
  endproperty
  a_shared_set: assert property (p_shared_set) else $error("shared line not taken");

  // protocol request on the trigger layer switches the mode one edge later
  sequence s_proto_cmd;
    cmd.valid && cmd.kind == sel_protocol && cmd.layer == TRIG_LAYER;
  endsequence
  sequence s_proto_taken;
    ##1 (proto_ff == $past(cmd.line[0]) && !err_ff);
  endsequence
  property p_proto_set;
    @(posedge clk) disable iff (init) s_proto_cmd |-> s_proto_taken;
  endproperty
  a_proto_set: assert property (p_proto_set) else $error("protocol not taken");
  // arm layers stay in separate-line mode; protocol or shared requests for them are refused
  property p_arm_proto;
    @(posedge clk) disable iff (init)
      (cmd.valid && cmd.layer != TRIG_LAYER && (cmd.kind == sel_protocol || cmd.kind == sel_shared))
      |=> (err_ff && $stable(proto_ff) && $stable(shared_ff));
  endproperty
  a_arm_proto: assert property (p_arm_proto) else $error("arm layer protocol request accepted");
  // the error flag only ever answers a command, it never rises by itself
  property p_err_idle;
    @(posedge clk) disable iff (init) !cmd.valid |=> !err_ff;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("error without command");

  // query outputs trail the stored selections by one edge
  property p_query;
    @(posedge clk) disable iff (rst) (query_layer == 2'h1) |=> (qin_ff == $past(in_ff[1]));
  endproperty
  a_query: assert property (p_query) else $error("query mismatch");
  property p_query_out;
    @(posedge clk) disable iff (rst) (query_layer == 2'h0) |=> (qout_ff == $past(out_ff[0]));
  endproperty
  a_query_out: assert property (p_query_out) else $error("output query mismatch");
endmodule : trigger_line_assignment
`default_nettype wire

//--- verification/trigger_bus_peer.sv
`timescale 1ns/100ps
`default_nettype none
// another instrument on the bus: flags a layer whose own lines collide
module trigger_bus_peer (
  input wire logic [8:0] in_lines, // packed input lines
  input wire logic [8:0] out_lines, // packed output lines
  output logic clash // a layer would hear its own trigger
);
  // a collided layer loops its output straight back into its input
  always_comb begin
    clash = 1'b0;
    for (int g = 0; g < 3; g++) begin
      clash |= (in_lines[3*g+:3] == out_lines[3*g+:3]);
    end
  end
endmodule : trigger_bus_peer
`default_nettype wire

//--- verification/test_trigger_line_assignment.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin $display("wrong value %s exp %h got %h", nm, e, g); n_fail++; end end
module test_trigger_line_assignment;
  import trigger_line_assignment_pkg::*;
  logic clk, rst, preset, cmd_error, shared_line_protocol, clash, chk_ff; // chk_ff: edge took a command
  cfg_cmd_t cmd; // write command
  logic [1:0] query_layer; // layer to report
  logic [2:0] query_in_line, query_out_line, shared_mode_line, sh_m; // sh_m: model shared line
  logic [8:0] sep_mode_input_line, sep_mode_output_line;
  logic [2:0] in_m [4], out_m [4]; // model selections, entry 3 unused
  logic pr_m; // model protocol
  logic [22:0] q [$], exp_v; // notes of expected state
  logic [31:0] r; // random word
  int n_fail, n_tests, seed, cyc;
  wire logic [22:0] seen = {cmd_error, sep_mode_input_line, sep_mode_output_line, shared_mode_line, shared_line_protocol};
  trigger_line_assignment #(.NUM_LAYERS(3)) trigger_line_assignment_i (.clk(clk), .rst(rst), .preset(preset),
    .cmd(cmd), .query_layer(query_layer), .query_in_line(query_in_line), .query_out_line(query_out_line),
    .shared_mode_line(shared_mode_line), .shared_line_protocol(shared_line_protocol),
    .sep_mode_input_line(sep_mode_input_line), .sep_mode_output_line(sep_mode_output_line), .cmd_error(cmd_error));
  trigger_bus_peer trigger_bus_peer_i (.in_lines(sep_mode_input_line), .out_lines(sep_mode_output_line), .clash(clash));
  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [22:0] snap(logic e);
    return {e, in_m[2], in_m[1], in_m[0], out_m[2], out_m[1], out_m[0], sh_m, pr_m};
  endfunction
  // defaults after reset or preset
  task automatic init_model;
    for (int g = 0; g < 4; g++) begin
      in_m[g] = 3'h1;
      out_m[g] = 3'h2;
    end
    sh_m = 3'h1;
    pr_m = 1'b0;
  endtask : init_model
  // drive one command and note what it must leave behind
  task automatic send(logic [1:0] ly, sel_kind_t k, logic [2:0] ln);
    logic ok;
    ok = (ln >= 3'h1) && (ln <= 3'h6);
    @(negedge clk);
    cmd = '{1'b1, ly, k, ln};
    case (k)
      sel_input: ok = ok && ly != 2'h3 && ln != out_m[ly];
      sel_output: ok = ok && ly != 2'h3 && ln != in_m[ly];
      sel_shared: ok = ok && ly == 2'h2;
      default: ok = ly == 2'h2; // protocol takes line[0], no range check
    endcase
    if (ok && k == sel_input) in_m[ly] = ln;
    if (ok && k == sel_output) out_m[ly] = ln;
    if (ok && k == sel_shared) sh_m = ln;
    if (ok && k == sel_protocol) pr_m = ln[0];
    q.push_back(snap(!ok));
  endtask : send
  task automatic idle;
    @(negedge clk);
    cmd.valid = 1'b0;
  endtask : idle
  // one cycle latency, layer 3 reads zero
  task automatic query_all;
    for (int g = 0; g < 4; g++) begin
      @(negedge clk);
      query_layer = g[1:0];
      @(negedge clk);
      `CHK("query_in_line", (g == 3) ? 3'h0 : in_m[g], query_in_line)
      `CHK("query_out_line", (g == 3) ? 3'h0 : out_m[g], query_out_line)
    end
  endtask : query_all
  task automatic conclude;
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // commands held during reset or preset are not taken
  always @(posedge clk) chk_ff <= cmd.valid && !rst && !preset;
  // compare each result with the oldest note
  always @(negedge clk) begin
    if (chk_ff) begin
      exp_v = q.pop_front();
      `CHK("state", exp_v, seen)
      `CHK("clash", 1'b0, clash)
    end else if (!rst) `CHK("cmd_error", 1'b0, cmd_error)
  end
  // hang guard, run needs well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    seed = 97;
    rst = 1'b1;
    preset = 1'b0;
    cmd = '0;
    query_layer = 2'h0;
    init_model();
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHK("after reset", snap(1'b0), seen)
    query_all();
    // clashes with defaults, range edges, wrong layers, back to back
    send(2'h2, sel_input, 3'h3);
    send(2'h2, sel_output, 3'h3);
    send(2'h0, sel_output, 3'h1);
    send(2'h1, sel_input, 3'h2);
    send(2'h0, sel_input, 3'h0);
    send(2'h0, sel_input, 3'h7);
    send(2'h3, sel_input, 3'h4);
    for (int i = 0; i < 16; i++) send(i[3:2], sel_kind_t'(i[1:0]), 3'h6);
    repeat (300) begin
      r = $random(seed);
      send(r[1:0], sel_kind_t'(r[3:2]), r[6:4]);
    end
    idle();
    query_all();
    // preset lands while a command is still offered
    send(2'h2, sel_input, 3'h5);
    @(negedge clk);
    preset = 1'b1;
    @(negedge clk);
    preset = 1'b0;
    cmd.valid = 1'b0;
    init_model();
    `CHK("after preset", snap(1'b0), seen)
    query_all();
    conclude();
  end
endmodule : test_trigger_line_assignment
`default_nettype wire
